// >>> hdl/usbdic_pkg.sv
// constants for the usb device init command decoder and mode registers
package usbdic_pkg;
    // command codes
    localparam logic [7:0] CMD_SET_ADDR = 8'hd0;
    localparam logic [7:0] CMD_SET_SECONDARY_ENDPOINT_ENABLE = 8'hd8;
    localparam logic [7:0] CMD_SET_MODE = 8'hf3;
    // address register layout
    localparam int ADDR_ENABLE_BIT = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    // endpoint enable register layout
    localparam int SECONDARY_ENDPOINT_ENABLE_BIT = 0;
    // configuration byte layout
    localparam int CFG_NO_SUSP_CLK_BIT = 1;
    localparam int CFG_CLK_RUN_BIT = 2;
    localparam int CFG_NAK_INT_BIT = 3;
    localparam int CFG_PULLUP_BIT = 4;
    localparam int CFG_EPMODE_LSB = 6;
    localparam logic [7:0] CFG_RESET = 8'h0e;
    // clock divide byte layout
    localparam int CDIV_SOF_ONLY_BIT = 7;
    localparam int CDIV_ONE_BIT = 6;
    localparam logic [7:0] CDIV_RESET = 8'h0b;
    localparam logic [3:0] CDIV_OFF = 4'hf;
    // endpoint configuration modes
    localparam logic [1:0] EPMODE_NON_ISO = 2'h0;
    localparam logic [1:0] EPMODE_ISO_OUT = 2'h1;
    localparam logic [1:0] EPMODE_ISO_IN = 2'h2;
    localparam logic [1:0] EPMODE_ISO_IO = 2'h3;
    // clock output rates
    localparam int FAST_CLK_HZ = 48000000;
    localparam int SUSP_CLK_HZ = 30000;
    // half period of the suspend clock in fast clock ticks
    localparam int SUSP_HALF_TICKS = FAST_CLK_HZ / (2 * SUSP_CLK_HZ);
    // decoder states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DATA1 = 3'b010,
        ST_DATA2 = 3'b100
    } usbdic_state_t;
endpackage

// >>> hdl/usbdic_clkdiv.sv
// clock output divider: fast clock over (divide+1), or the suspend rate
`timescale 1ns/1ns
module usbdic_clkdiv (
    // clocks and reset
    input wire logic fast_clk,
    input wire logic rst_n,
    // control
    input wire logic [3:0] divide,
    input wire logic slow_mode,
    // clock out
    output logic clk_out
);
    logic [9:0] count;
    logic [9:0] next_count;
    logic next_clk_out;
    logic [9:0] limit;
    // settings arrive from the system clock domain
    logic [3:0] div_meta;
    logic [3:0] div_sync;
    logic [3:0] div_prev;
    logic [3:0] div_live;
    logic [3:0] next_div_live;
    logic [1:0] slow_sync;

    // two flops per bit; a word is taken only once it held for two samples,
    // so a skewed multi-bit change never reaches the counter half-formed
    always_ff @(posedge fast_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_meta <= usbdic_pkg::CDIV_RESET[3:0];
            div_sync <= usbdic_pkg::CDIV_RESET[3:0];
            div_prev <= usbdic_pkg::CDIV_RESET[3:0];
            slow_sync <= 2'h0;
        end else begin
            div_meta <= divide;
            div_sync <= div_meta;
            div_prev <= div_sync;
            slow_sync <= {slow_sync[0], slow_mode};
        end
    end

    // toggle period: full divide period split into high and low phases
    always_comb begin
        next_div_live = (div_sync == div_prev) ? div_sync : div_live;
        limit = slow_sync[1] ? 10'(usbdic_pkg::SUSP_HALF_TICKS - 1) : {6'h0, div_live};
        next_count = count + 10'h001;
        next_clk_out = clk_out;
        if (div_live == usbdic_pkg::CDIV_OFF && !slow_sync[1]) begin
            next_count = 10'h000;
            next_clk_out = 1'b0;
        end else if (slow_sync[1]) begin
            if (count >= limit) begin
                next_count = 10'h000;
                next_clk_out = ~clk_out;
            end
        end else if (count >= limit) begin
            next_count = 10'h000;
            next_clk_out = 1'b1;
        end else begin
            // high for the lower half of the period
            next_clk_out = (count + 10'h001) <= (limit >> 1);
        end
    end

    always_ff @(posedge fast_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 10'h000;
            clk_out <= 1'b0;
            div_live <= usbdic_pkg::CDIV_RESET[3:0];
        end else begin
            count <= next_count;
            clk_out <= next_clk_out;
            div_live <= next_div_live;
        end
    end
endmodule

// >>> hdl/usbdic_top.sv
// init command decoder and configuration registers of the usb device
`timescale 1ns/1ns

// Overview of operation
// - address bits 6-0 hold device address, cleared by usb bus reset
// - bit 7 is function enable, set by usb bus reset
// - endpoint enable bit 0 enables secondary and primary endpoints; control always on
// - secondary endpoints stay disabled unless function enable is set
// - mode bit 1 clear: clock output drops to 30 kHz in suspend
// - mode bit 2 clear: internal clocks stop during suspend
// - mode bit 3 set: nak and error transactions raise interrupts
// - mode bit 4 connects d+ pull-up only with bus voltage present
// - mode and divider settings survive a usb bus reset
// - mode bits 7-6 select primary endpoint configuration, reset 00
// - clock output is 48 mhz over divide value plus one
// - divide field resets to 1011 for a 4 mhz clock output
// - divide value 1111 stops the clock output unless the 30 kHz suspend rate is selected
// - sof-only mode: interrupt pin asserts only on start-of-frame
// - set-mode code takes exactly two data bytes, config then divide
// - otherwise interrupt on any pending bit, plus sof if pin mode set
module usbdic_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fast_clk,
    // command port from the microcontroller interface
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    // usb core status
    input wire logic usb_bus_reset,
    input wire logic usb_suspend,
    input wire logic vbus_present,
    input wire logic sof_received,
    input wire logic int_pending,
    input wire logic int_pin_mode,
    // configuration outputs
    output logic [6:0] device_address,
    output logic function_enable,
    output logic control_endpoint_enable,
    output logic secondary_endpoint_enable,
    output logic primary_endpoint_enable,
    output logic [1:0] primary_endpoint_mode,
    output logic nak_error_int_enable,
    output logic internal_clock_run,
    output logic dplus_pullup_enable,
    output logic must_be_one_bit,
    output logic int_request,
    output logic clock_output_pin
);
    // synchronised pin-side inputs
    logic [1:0] sync_reset;
    logic [1:0] sync_susp;
    logic [1:0] sync_vbus;
    logic bus_reset;
    logic suspended;
    logic vbus_ok;

    // decoder and register state
    usbdic_pkg::usbdic_state_t state;
    usbdic_pkg::usbdic_state_t next_state;
    logic [7:0] active_cmd;
    logic [7:0] next_active_cmd;
    logic [7:0] cfg_hold;
    logic [7:0] next_cfg_hold;
    logic [7:0] addr_reg;
    logic [7:0] next_addr_reg;
    logic ep_reg;
    logic next_ep_reg;
    logic [7:0] cfg_reg;
    logic [7:0] next_cfg_reg;
    logic [7:0] cdiv_reg;
    logic [7:0] next_cdiv_reg;
    logic next_int_request;
    logic next_ctl_en;
    logic next_pullup;
    logic next_clk_run;
    logic slow_clk;
    logic divided_clk;

    // two flops on the bus reset, suspend and vbus inputs; sof and interrupt inputs enter directly
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reset <= 2'h0;
            sync_susp <= 2'h0;
            sync_vbus <= 2'h0;
        end else begin
            sync_reset <= {sync_reset[0], usb_bus_reset};
            sync_susp <= {sync_susp[0], usb_suspend};
            sync_vbus <= {sync_vbus[0], vbus_present};
        end
    end
    assign bus_reset = sync_reset[1];
    assign suspended = sync_susp[1];
    assign vbus_ok = sync_vbus[1];

    // command decoder: data bytes staged, registers written on the last one
    always_comb begin
        next_state = state;
        next_active_cmd = active_cmd;
        next_cfg_hold = cfg_hold;
        next_addr_reg = addr_reg;
        next_ep_reg = ep_reg;
        next_cfg_reg = cfg_reg;
        next_cdiv_reg = cdiv_reg;
        if (cmd_valid) begin
            // a new code aborts any unfinished data phase; nothing applied
            next_active_cmd = cmd_code;
            case (cmd_code)
                usbdic_pkg::CMD_SET_ADDR,
                usbdic_pkg::CMD_SET_SECONDARY_ENDPOINT_ENABLE,
                usbdic_pkg::CMD_SET_MODE: next_state = usbdic_pkg::ST_DATA1;
                default: next_state = usbdic_pkg::ST_IDLE;
            endcase
        end else if (data_valid) begin
            case (state)
                usbdic_pkg::ST_DATA1: begin
                    next_state = usbdic_pkg::ST_IDLE;
                    case (active_cmd)
                        usbdic_pkg::CMD_SET_ADDR: next_addr_reg = data_byte;
                        usbdic_pkg::CMD_SET_SECONDARY_ENDPOINT_ENABLE: begin
                            next_ep_reg = data_byte[usbdic_pkg::SECONDARY_ENDPOINT_ENABLE_BIT];
                        end
                        usbdic_pkg::CMD_SET_MODE: begin
                            // first byte held until the second arrives
                            next_cfg_hold = data_byte;
                            next_state = usbdic_pkg::ST_DATA2;
                        end
                        default: next_state = usbdic_pkg::ST_IDLE;
                    endcase
                end
                usbdic_pkg::ST_DATA2: begin
                    next_cfg_reg = cfg_hold;
                    next_cdiv_reg = data_byte;
                    next_state = usbdic_pkg::ST_IDLE;
                end
                default: next_state = usbdic_pkg::ST_IDLE;
            endcase
        end
        // bus reset touches only the address register
        if (bus_reset) begin
            next_addr_reg = {1'b1, usbdic_pkg::ADDR_RESET};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= usbdic_pkg::ST_IDLE;
            active_cmd <= 8'h00;
            cfg_hold <= 8'h00;
            addr_reg <= 8'h00;
            ep_reg <= 1'b0;
            cfg_reg <= usbdic_pkg::CFG_RESET;
            cdiv_reg <= usbdic_pkg::CDIV_RESET;
        end else begin
            state <= next_state;
            active_cmd <= next_active_cmd;
            cfg_hold <= next_cfg_hold;
            addr_reg <= next_addr_reg;
            ep_reg <= next_ep_reg;
            cfg_reg <= next_cfg_reg;
            cdiv_reg <= next_cdiv_reg;
        end
    end

    // derived controls; interrupt source chosen by sof-only and pin mode
    always_comb begin
        next_ctl_en = 1'b1;
        next_pullup = cfg_reg[usbdic_pkg::CFG_PULLUP_BIT] & vbus_ok;
        // clocks stop in suspend only when the run bit is clear
        next_clk_run = cfg_reg[usbdic_pkg::CFG_CLK_RUN_BIT] | ~suspended;
        if (cdiv_reg[usbdic_pkg::CDIV_SOF_ONLY_BIT]) begin
            next_int_request = sof_received;
        end else begin
            next_int_request = int_pending | (int_pin_mode & sof_received);
        end
    end

    // every output registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_address <= 7'h00;
            function_enable <= 1'b0;
            control_endpoint_enable <= 1'b0;
            secondary_endpoint_enable <= 1'b0;
            primary_endpoint_enable <= 1'b0;
            primary_endpoint_mode <= 2'h0;
            nak_error_int_enable <= 1'b0;
            internal_clock_run <= 1'b0;
            dplus_pullup_enable <= 1'b0;
            must_be_one_bit <= 1'b0;
            int_request <= 1'b0;
        end else begin
            device_address <= addr_reg[6:0];
            function_enable <= addr_reg[usbdic_pkg::ADDR_ENABLE_BIT];
            control_endpoint_enable <= next_ctl_en;
            // gated so endpoints stay off while function disabled
            secondary_endpoint_enable <= ep_reg & addr_reg[usbdic_pkg::ADDR_ENABLE_BIT];
            primary_endpoint_enable <= ep_reg & addr_reg[usbdic_pkg::ADDR_ENABLE_BIT];
            primary_endpoint_mode <= cfg_reg[usbdic_pkg::CFG_EPMODE_LSB +: 2];
            nak_error_int_enable <= cfg_reg[usbdic_pkg::CFG_NAK_INT_BIT];
            internal_clock_run <= next_clk_run;
            dplus_pullup_enable <= next_pullup;
            must_be_one_bit <= cdiv_reg[usbdic_pkg::CDIV_ONE_BIT];
            int_request <= next_int_request;
        end
    end

    // suspend-rate select; held static, fast domain reads it as a slow level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_clk <= 1'b0;
        end else begin
            slow_clk <= suspended & ~cfg_reg[usbdic_pkg::CFG_NO_SUSP_CLK_BIT];
        end
    end

    // divider runs on the 48 mhz reference
    usbdic_clkdiv u_clkdiv (
        .fast_clk(fast_clk),
        .rst_n(rst_n),
        .divide(cdiv_reg[3:0]),
        .slow_mode(slow_clk),
        .clk_out(divided_clk)
    );
    assign clock_output_pin = divided_clk;

    // decoder state must remain one-hot
    property p_onehot_state;
        @(posedge sys_clk) disable iff (!rst_n) $onehot(state);
    endproperty
    a_onehot_state: assert property (p_onehot_state) else $error("state not one-hot");

    property p_bus_reset_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_reset |-> ##2 (device_address == 7'h00 && function_enable);
    endproperty
    a_bus_reset_addr: assert property (p_bus_reset_addr) else $error("bus reset address");

    property p_bus_reset_fen;
        @(posedge sys_clk) disable iff (!rst_n) bus_reset |=> addr_reg[7];
    endproperty
    a_bus_reset_fen: assert property (p_bus_reset_fen) else $error("function not enabled");

    property p_ep_gated;
        @(posedge sys_clk) disable iff (!rst_n) secondary_endpoint_enable |-> $past(addr_reg[7]);
    endproperty
    a_ep_gated: assert property (p_ep_gated) else $error("endpoint without function");

    property p_ctl_on;
        @(posedge sys_clk) disable iff (!rst_n) $past(rst_n) |-> control_endpoint_enable;
    endproperty
    a_ctl_on: assert property (p_ctl_on) else $error("control endpoint off");

    property p_mode_kept;
        @(posedge sys_clk) disable iff (!rst_n)
        (bus_reset && !(data_valid && state == usbdic_pkg::ST_DATA2)) |=> $stable(cfg_reg);
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("mode lost on bus reset");

    property p_mode_two_bytes;
        @(posedge sys_clk) disable iff (!rst_n)
        (state == usbdic_pkg::ST_DATA1 && data_valid && !cmd_valid) |=> $stable(cfg_reg);
    endproperty
    a_mode_two_bytes: assert property (p_mode_two_bytes) else $error("early mode apply");

    property p_sof_only;
        @(posedge sys_clk) disable iff (!rst_n)
        (cdiv_reg[7] && !sof_received) |=> !int_request;
    endproperty
    a_sof_only: assert property (p_sof_only) else $error("irq outside sof");

    property p_normal_int;
        @(posedge sys_clk) disable iff (!rst_n)
        ($past(rst_n) && !cdiv_reg[7] && int_pending) |=> int_request;
    endproperty
    a_normal_int: assert property (p_normal_int) else $error("pending irq missed");

    property p_pullup;
        @(posedge sys_clk) disable iff (!rst_n)
        dplus_pullup_enable |-> $past(cfg_reg[4] && vbus_ok);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pullup without enable");

    // suspend with the run bit clear must stop the internal clocks
    property p_clk_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (suspended && !cfg_reg[usbdic_pkg::CFG_CLK_RUN_BIT]) |=> !internal_clock_run;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clocks run in suspend");

    // slow output rate only in suspend with the keep-rate bit clear
    property p_slow_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |->
            (slow_clk == $past(suspended && !cfg_reg[usbdic_pkg::CFG_NO_SUSP_CLK_BIT]));
    endproperty
    a_slow_sel: assert property (p_slow_sel) else $error("wrong suspend rate select");

    // primary endpoint mode follows the configuration byte
    property p_epmode;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |->
            (primary_endpoint_mode == $past(cfg_reg[usbdic_pkg::CFG_EPMODE_LSB +: 2]));
    endproperty
    a_epmode: assert property (p_epmode) else $error("endpoint mode mismatch");

    // nak and error interrupt enable follows its mode bit
    property p_nak_en;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |->
            (nak_error_int_enable == $past(cfg_reg[usbdic_pkg::CFG_NAK_INT_BIT]));
    endproperty
    a_nak_en: assert property (p_nak_en) else $error("nak interrupt enable mismatch");
endmodule

// >>> test/usbdic_mcu_model.sv
// microcontroller model driving command and data bytes into the decoder
`timescale 1ns/1ns
module usbdic_mcu_model (
    // clock
    input wire logic sys_clk,
    // command port
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic data_valid,
    output logic [7:0] data_byte
);
    int gap = 0;
    // quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        data_valid = 1'b0;
        cmd_code = 8'h00;
        data_byte = 8'h00;
    end
    // one byte per cycle; called just after a rising edge
    task automatic put(input logic is_cmd, input logic [7:0] b);
        cmd_valid <= is_cmd;
        data_valid <= !is_cmd;
        if (is_cmd) cmd_code <= b;
        else data_byte <= b;
        @(posedge sys_clk);
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge sys_clk);
        end
    endtask
    // released lines show stale garbage, not the last byte
    task automatic idle();
        cmd_valid <= 1'b0;
        data_valid <= 1'b0;
        cmd_code <= ~cmd_code;
        data_byte <= ~data_byte;
    endtask
    // single data byte commands
    task automatic write1(input logic [7:0] code, input logic [7:0] b);
        put(1'b1, code);
        put(1'b0, b);
        idle();
        @(posedge sys_clk);
    endtask
    // config byte first, divide byte second, reserved bits zero
    task automatic set_mode(input logic [7:0] cfg, input logic [7:0] cdiv);
        put(1'b1, usbdic_pkg::CMD_SET_MODE);
        put(1'b0, cfg & 8'hde);
        put(1'b0, (cdiv & 8'hcf) | 8'h40);
        idle();
        @(posedge sys_clk);
    endtask
endmodule

// >>> test/usb_device_init_command_regs_tb_top.sv
// self-checking bench for the init command decoder and mode registers
`timescale 1ns/1ns
module usb_device_init_command_regs_tb_top;
    logic sys_clk = 1'b0;
    logic fast_clk = 1'b0;
    logic rst_n = 1'b0;
    logic usb_bus_reset = 1'b0;
    logic usb_suspend = 1'b0;
    logic vbus_present = 1'b1;
    logic sof_received = 1'b0;
    logic int_pending = 1'b0;
    logic int_pin_mode = 1'b0;
    logic cmd_valid, data_valid, function_enable, control_endpoint_enable;
    logic secondary_endpoint_enable, primary_endpoint_enable, nak_error_int_enable;
    logic internal_clock_run, dplus_pullup_enable, must_be_one_bit, int_request;
    logic clock_output_pin, m_ep;
    logic [7:0] cmd_code, data_byte, m_addr, m_cfg, m_cdiv;
    logic [6:0] device_address;
    logic [1:0] primary_endpoint_mode;
    logic [31:0] seed = 32'h8b04c423;
    int n_errors = 0;
    int checks_done = 0;
    int ticks;
    // system clock 8 ns, divider reference unrelated to it
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        forever #10 fast_clk = ~fast_clk;
    end
    usbdic_top i_dut (.sys_clk, .rst_n, .fast_clk, .cmd_valid, .cmd_code, .data_valid,
        .data_byte, .usb_bus_reset, .usb_suspend, .vbus_present, .sof_received,
        .int_pending, .int_pin_mode, .device_address, .function_enable,
        .control_endpoint_enable, .secondary_endpoint_enable, .primary_endpoint_enable,
        .primary_endpoint_mode, .nak_error_int_enable, .internal_clock_run,
        .dplus_pullup_enable, .must_be_one_bit, .int_request, .clock_output_pin);
    usbdic_mcu_model i_mcu (.sys_clk, .cmd_valid, .cmd_code, .data_valid, .data_byte);
    // verdict
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // interrupt source by sof-only, pending, pin mode, sof
    function automatic logic exp_int(input logic [3:0] s);
        return s[3] ? s[0] : (s[2] | (s[1] & s[0]));
    endfunction
    // output period in reference ticks, zero when stopped
    function automatic int exp_period(input logic [7:0] cdiv, input logic slow);
        return slow ? 2 * usbdic_pkg::SUSP_HALF_TICKS :
            (cdiv[3:0] == 4'hf) ? 0 : int'(cdiv[3:0]) + 1;
    endfunction
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        m_addr = 8'h00;
        m_ep = 1'b0;
        m_cfg = usbdic_pkg::CFG_RESET;
        m_cdiv = usbdic_pkg::CDIV_RESET;
        @(posedge sys_clk);
    endtask
    // outputs settle a few edges after the last byte
    task automatic chk_all();
        repeat (4) @(posedge sys_clk);
        check(16'(device_address), 16'(m_addr[6:0]));
        check(16'(function_enable), 16'(m_addr[7]));
        check(16'(control_endpoint_enable), 16'h1);
        check(16'(secondary_endpoint_enable), 16'(m_ep & m_addr[7]));
        check(16'(primary_endpoint_enable), 16'(m_ep & m_addr[7]));
        check(16'(primary_endpoint_mode), 16'(m_cfg[7:6]));
        check(16'(nak_error_int_enable), 16'(m_cfg[3]));
        check(16'(dplus_pullup_enable), 16'(m_cfg[4] & vbus_present));
        check(16'(must_be_one_bit), 16'(m_cdiv[6]));
    endtask
    // second measurement only, the first may span a rate change
    task automatic chk_clk();
        int n;
        int rises;
        logic prev;
        for (int k = 0; k < 2; k++) begin
            rises = 0;
            ticks = 0;
            prev = clock_output_pin;
            for (n = 0; n < 4000 && rises < 2; n++) begin
                @(posedge fast_clk);
                if (rises == 1) ticks++;
                if (clock_output_pin === 1'b1 && prev === 1'b0) rises++;
                prev = clock_output_pin;
            end
            if (rises < 2) ticks = 0;
        end
        check(16'(ticks), 16'(exp_period(m_cdiv, usb_suspend & ~m_cfg[1])));
        @(posedge sys_clk);
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        do_reset();
        chk_all();
        check(16'(internal_clock_run), 16'h1);
        chk_clk();
        // endpoints refused while function disabled
        i_mcu.write1(usbdic_pkg::CMD_SET_SECONDARY_ENDPOINT_ENABLE, 8'h01);
        m_ep = 1'b1;
        chk_all();
        // mode settings must survive a bus reset, address must not
        i_mcu.write1(usbdic_pkg::CMD_SET_ADDR, 8'h2a);
        m_cfg = 8'hd0;
        m_cdiv = 8'h45;
        i_mcu.set_mode(m_cfg, m_cdiv);
        usb_bus_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        usb_bus_reset <= 1'b0;
        m_addr = 8'h80;
        chk_all();
        chk_clk();
        vbus_present <= 1'b0;
        chk_all();
        vbus_present <= 1'b1;
        // half set-mode, then aborted by a new code, then strays
        i_mcu.put(1'b1, usbdic_pkg::CMD_SET_MODE);
        i_mcu.put(1'b0, 8'h88);
        i_mcu.idle();
        chk_all();
        i_mcu.put(1'b1, usbdic_pkg::CMD_SET_MODE);
        i_mcu.put(1'b0, 8'h48);
        i_mcu.write1(usbdic_pkg::CMD_SET_SECONDARY_ENDPOINT_ENABLE, 8'h00);
        m_ep = 1'b0;
        i_mcu.put(1'b0, 8'hff);
        i_mcu.write1(8'hfb, 8'h01);
        chk_all();
        // random settings, every endpoint mode, slow host at times
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            i_mcu.gap = i % 3;
            m_addr = seed[31:24];
            m_ep = seed[16];
            m_cfg = {2'(i), 1'b0, seed[4:1], 1'b0};
            m_cdiv = {2'b01, 2'b00, 4'(1 + seed[15:8] % 12)};
            i_mcu.write1(usbdic_pkg::CMD_SET_ADDR, m_addr);
            i_mcu.write1(usbdic_pkg::CMD_SET_SECONDARY_ENDPOINT_ENABLE, {7'h00, m_ep});
            i_mcu.set_mode(m_cfg, m_cdiv);
            chk_all();
            chk_clk();
        end
        i_mcu.gap = 0;
        // suspend with slow clock and stopped core clocks, then without
        m_cfg = 8'h00;
        m_cdiv = 8'h43;
        i_mcu.set_mode(m_cfg, m_cdiv);
        usb_suspend <= 1'b1;
        chk_all();
        check(16'(internal_clock_run), 16'h0);
        chk_clk();
        m_cfg = 8'h06;
        i_mcu.set_mode(m_cfg, m_cdiv);
        chk_all();
        check(16'(internal_clock_run), 16'h1);
        chk_clk();
        usb_suspend <= 1'b0;
        m_cdiv = 8'h4f;
        i_mcu.set_mode(m_cfg, m_cdiv);
        chk_clk();
        // every interrupt source combination in both pin modes
        for (int i = 0; i < 16; i++) begin
            if (i % 8 == 0) begin
                m_cdiv = {i[3], 7'h4b};
                i_mcu.set_mode(m_cfg, m_cdiv);
            end
            int_pending <= i[2];
            int_pin_mode <= i[1];
            sof_received <= i[0];
            repeat (3) @(posedge sys_clk);
            check(16'(int_request), 16'(exp_int(4'(i))));
        end
        // second reset in mid-run restores defaults
        do_reset();
        chk_all();
        chk_clk();
        report_and_stop();
    end
endmodule
